/* File: testbench/mcu_model.sv */
// controller model: drives the kick pin steadily, hung, with short pulses or not at all
`timescale 1ns/1ps
module mcu_model
#(
	parameter int unsigned KickGap = 16
)
(
	input  wire logic       clk,       // controller clock
	input  wire logic       rstIn,     // reset from the supervisor, active high
	input  wire logic [1:0] modeIn,    // 0 toggle, 1 hold, 2 short pulse, 3 released
	output logic            kickOut,   // kick pin level
	output logic            drivenOut  // kick pin is actively driven
);
	logic [7:0] gap_q = 8'h00;
	logic       lvl_q = 1'b0;

	// a released pin has no pull, so it shows a level that changes every cycle
	assign drivenOut = (modeIn != 2'h3);
	assign kickOut   = lvl_q;

	always_ff @(posedge clk)
	begin
		gap_q <= (gap_q >= 8'(KickGap - 1)) ? 8'h00 : gap_q + 8'h01;
		if (modeIn == 2'h3)
			lvl_q <= ~lvl_q;
		else if (rstIn || modeIn == 2'h1)
			lvl_q <= lvl_q;                 // a controller in reset or hung does not kick
		else if (modeIn == 2'h0 && gap_q == 8'h00)
			lvl_q <= ~lvl_q;
		else if (modeIn == 2'h2)
			lvl_q <= (gap_q == 8'h00);
	end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the supply supervisor with a controller model on the kick pin
`timescale 1ns/1ps
module testbench;
	import supervisor_pkg::*;
	localparam int RecCyc = 20;
	localparam int WdCyc  = 64;

	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       supplyOk = 1'b0;
	logic       buttonB = 1'b1;
	logic [1:0] kickMode = 2'h0;
	logic       kick;
	logic       kickDriven;
	apb_req_t   apbReq = '0;
	apb_rsp_t   apbRsp;
	logic       resetB;
	logic       resetHi;
	logic       odOut;
	logic       odOe;
	int         mismatches = 0;
	int         cmp_count = 0;

	always #25 clk = ~clk;

	supply_supervisor_watchdog_reset #(.RecCycles(RecCyc), .WdCycles(WdCyc)) dut_u
	(
		.clk(clk), .rst_b(rst_b), .supplyOkIn(supplyOk), .manual_reset_n_in(buttonB),
		.watchdog_kick_in(kick), .kickDrivenIn(kickDriven), .apbReq(apbReq),
		.apbRsp(apbRsp), .rstLowOut(resetB), .rstHighOut(resetHi), .rstOdOut(odOut),
		.rstOdOe(odOe)
	);

	mcu_model #(.KickGap(16)) mcu_u
	(
		.clk(clk), .rstIn(resetHi), .modeIn(kickMode), .kickOut(kick), .drivenOut(kickDriven)
	);

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input bit ok, input string msg);
		cmp_count++;
		if (!ok)
		begin
			mismatches++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	// bounded wait for the reset output to reach a level, n is cycles waited
	task automatic wait_level(input logic lvl, input int bound, output int n);
		n = 0;
		while (resetHi !== lvl && n < bound)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= bound)
		begin
			check(1'b0, "reset output wait timed out");
			print_verdict();
		end
	endtask

	task automatic stay_released(input int n, input string msg);
		int bad;
		bad = 0;
		repeat (n)
		begin
			@(negedge clk);
			if (resetHi !== 1'b0)
				bad++;
		end
		check(bad == 0, msg);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		// answer is looked at and taken mid-cycle, while it stands; the request drops at the next rising edge
		@(negedge clk);
		while (apbRsp.pready !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		@(posedge clk);
		apbReq <= '0;
		if (n >= 20)
		begin
			check(1'b0, "bus answer timed out");
			print_verdict();
		end
	endtask

	// the two reset outputs must never disagree
	always @(negedge clk)
		check(resetHi === ~resetB, "high and low outputs disagree");

	// push-pull build: the open-drain pair must stay idle
	always @(negedge clk)
		check(odOe === 1'b0 && odOut === 1'b0, "open-drain pin active in push-pull build");

	task automatic power_up();
		int len;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(negedge clk);
		check(resetHi === 1'b1, "reset not held on low supply");
		@(posedge clk);
		supplyOk <= 1'b1;
		wait_level(1'b0, 200, len);
		check(len >= RecCyc && len <= RecCyc + 8, "power-up hold wrong length");
	endtask

	task automatic supply_dip();
		int n;
		@(posedge clk);
		supplyOk <= 1'b0;
		wait_level(1'b1, 8, n);
		repeat (5) @(posedge clk);
		supplyOk <= 1'b1;
		repeat (RecCyc / 2) @(posedge clk);
		supplyOk <= 1'b0;
		repeat (3) @(posedge clk);
		supplyOk <= 1'b1;
		wait_level(1'b0, 200, n);
		check(n >= RecCyc, "recovery timer not cleared by dip");
	endtask

	task automatic button_bounce();
		int   n;
		int   rises;
		logic prev;
		rises = 0;
		prev = resetHi;
		stay_released(40, "open button caused reset");
		for (int i = 0; i < 38; i++)
		begin
			@(posedge clk);
			buttonB <= (i < 4 || i >= 34) ? i[0] : 1'b0;
			@(negedge clk);
			rises += (resetHi === 1'b1 && prev !== 1'b1);
			prev = resetHi;
			if (i == 30)
				check(resetHi === 1'b1, "reset not held while button low");
		end
		@(posedge clk);
		buttonB <= 1'b1;
		wait_level(1'b0, 200, n);
		check(n >= RecCyc, "button release hold too short");
		check(rises == 1, "bouncing press gave more than one reset");
	endtask

	task automatic kick_service();
		stay_released(5 * WdCyc, "toggled kick still timed out");
		@(posedge clk);
		kickMode <= 2'h2;
		stay_released(5 * WdCyc, "shortest kick pulses not seen");
		@(posedge clk);
		kickMode <= 2'h3;
		stay_released(5 * WdCyc, "undriven kick pin caused reset");
		@(posedge clk);
		kickMode <= 2'h0;
	endtask

	task automatic kick_timeout();
		int n;
		@(posedge clk);
		kickMode <= 2'h1;
		wait_level(1'b1, WdCyc + 20, n);
		wait_level(1'b0, 200, n);
		check(n >= RecCyc, "watchdog reset too short");
		stay_released(WdCyc - 4, "watchdog not cleared by its reset");
		wait_level(1'b1, 12, n);
		wait_level(1'b0, 200, n);
	endtask

	task automatic hold_during_reset();
		int n;
		@(posedge clk);
		buttonB <= 1'b0;
		repeat (2 * WdCyc) @(posedge clk);
		buttonB <= 1'b1;
		wait_level(1'b0, 200, n);
		stay_released(WdCyc - 4, "watchdog counted while reset held");
		wait_level(1'b1, 12, n);
		@(posedge clk);
		kickMode <= 2'h0;
		wait_level(1'b0, 200, n);
	endtask

	task automatic register_access();
		logic [31:0] rd;
		logic        err;
		int          n;
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check(rd === 32'h1 && err === 1'b0, "control reset value wrong");
		apb(1'b0, 12'h004, 32'h0, rd, err);
		check(rd[1:0] === 2'b10 && err === 1'b0, "status level bits wrong");
		apb(1'b1, 12'h008, 32'h3, rd, err);
		check(err === 1'b1 && resetHi === 1'b0, "unmapped write not refused");
		apb(1'b1, 12'h000, 32'h3, rd, err);
		wait_level(1'b1, 10, n);
		wait_level(1'b0, 200, n);
		check(n >= RecCyc, "software reset too short");
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		check(1'b0, "run limit reached");
		print_verdict();
	end

	initial
	begin
		power_up();
		supply_dip();
		button_bounce();
		kick_service();
		kick_timeout();
		hold_during_reset();
		register_access();
		print_verdict();
	end
endmodule

/* File: verilog/period_timer.sv */
// up-counter that flags the last cycle of a fixed period; clear wins over counting
`timescale 1ns/1ps
module period_timer
#(
	parameter int unsigned Limit = 2,
	parameter int unsigned W     = $clog2(Limit + 1)
)
(
	input  wire logic         clk,    // system clock
	input  wire logic         rst_b,  // async reset, active low
	input  wire logic         clr,    // hold count at zero
	input  wire logic         run,    // count this cycle
	output logic      [W-1:0] count,  // current count
	output logic              done    // last cycle of the period
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	if (Limit < 2)
	begin : g_bad_limit
		$error("period_timer: Limit must be at least 2");
	end

	assign done  = run && !clr && (cnt_q == W'(Limit - 1));
	assign count = cnt_q;

	always_comb
	begin
		cnt_d = cnt_q;
		if (clr || done)
			cnt_d = '0;
		else if (run)
			cnt_d = cnt_q + W'(1);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule

/* File: verilog/supervisor_defs.svh */
// offsets, field positions, reset values and timing figures of the supply supervisor
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define CLK_MHZ           20
`define CLK_PERIOD_NS     50

`define REC_TIME_US       200000
`define WD_TIME_US        1600000
`define MR_GLITCH_NS      100
`define KICK_MIN_NS       50

`define OFF_CTRL          12'h000
`define OFF_STATUS        12'h004

`define CTRL_WDEN_BIT     0
`define CTRL_SWRST_BIT    1
`define CTRL_WDEN_RESET   1'b1

`define STAT_RST_BIT      0
`define STAT_SUPPLY_BIT   1
`define STAT_MANUAL_BIT   2
`define STAT_DRIVEN_BIT   3
`define STAT_CAUSE_LSB    4
`define CAUSE_W           4

`define LOW_OUT_NONE      0
`define LOW_OUT_PUSH_PULL 1
`define LOW_OUT_OPEN_DRN  2

`endif

/* File: verilog/supervisor_pkg.sv */
// types shared by the supply supervisor modules
package supervisor_pkg;

	typedef enum logic [1:0]
	{
		ST_HOLD    = 2'b00,
		ST_RECOVER = 2'b01,
		ST_RUN     = 2'b11
	} sup_state_t;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed
	{
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

endpackage

/* File: verilog/supply_supervisor_watchdog_reset.sv */
// supply supervisor: reset generator with manual input, watchdog and APB status
//
// How it works
// - reset on low supply, manual input, watchdog
// - after supply rises, hold reset recovery period
// - every reset lasts at least recovery period
// - low supply clears recovery timer until restored
// - manual low holds reset, then recovery period
// - open manual input reads high, no reset
// - switch bounce gives one clean reset
// - untoggled kick for timeout asserts reset
// - kick edges and resets clear watchdog
// - shortest kick pulse still clears watchdog
// - watchdog cleared and idle while reset asserted
// - watchdog reset lasts full recovery period
// - floating kick input never trips watchdog
// - undriven kick serviced by internal pulse
// - high output inverse of low output when both present
// - open-drain output sinks only during reset
// - recovery period is a build option
// - watchdog, manual input, outputs per variant
`timescale 1ns/1ps
`include "supervisor_defs.svh"
module supply_supervisor_watchdog_reset
#(
	parameter int unsigned RecCycles  = `REC_TIME_US * `CLK_MHZ,
	parameter int unsigned WdCycles   = `WD_TIME_US * `CLK_MHZ,
	parameter bit          HasWatchdog = 1'b1,
	parameter bit          HasManual   = 1'b1,
	parameter int unsigned LowOutMode  = `LOW_OUT_PUSH_PULL,
	parameter bit          HasHighOut  = 1'b1
)
(
	input  wire logic                     clk,               // 20 MHz timebase
	input  wire logic                     rst_b,             // async reset, active low
	input  wire logic                     supplyOkIn,        // supply above trip level
	input  wire logic                     manual_reset_n_in, // push-button, active low
	input  wire logic                     watchdog_kick_in,  // kick pin level
	input  wire logic                     kickDrivenIn,      // kick pin has an active driver
	input  wire supervisor_pkg::apb_req_t apbReq,            // APB request
	output supervisor_pkg::apb_rsp_t      apbRsp,            // APB response
	output logic                          rstLowOut,         // reset, active low, push-pull
	output logic                          rstHighOut,        // reset, active high
	output logic                          rstOdOut,          // open-drain data, always low
	output logic                          rstOdOe            // open-drain sink enable
);
	import supervisor_pkg::*;

	localparam int unsigned GlitchCycles = (`MR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned KickCycles   = (`KICK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned SvcCycles    = WdCycles / 2;
	localparam int unsigned WdW          = $clog2(WdCycles + 1);

	// the kick path may not filter longer than the shortest valid pulse
	if (KickCycles != 1)
	begin : g_bad_kick
		$error("kick pulse shorter than one clock cannot be caught");
	end
	if (RecCycles < 2 || WdCycles < 4 || LowOutMode > `LOW_OUT_OPEN_DRN)
	begin : g_bad_cfg
		$error("unsupported supervisor configuration");
	end

	sup_state_t  state_q;
	sup_state_t  state_d;
	logic        supplyS;
	logic        mrS;
	logic        kickS;
	logic        drivenS;
	logic        mrLow;
	logic        levelCause;
	logic        recDone;
	logic        wdExpire;
	logic        wdClr;
	logic        svcDone;
	logic        kickEdge;
	logic        kickLevel;
	logic [WdW-1:0] wdCount;
	logic        rstLow_q;
	logic        rstLow_d;
	logic        rstHigh_q;
	logic        rstHigh_d;
	logic        odOe_q;
	logic        odOe_d;
	logic        kickPrev_q;
	logic        kickPrev_d;
	logic        svcPulse_q;
	logic        svcPulse_d;
	logic        wdEn_q;
	logic        wdEn_d;
	logic        swRst_q;
	logic        swRst_d;
	logic [`CAUSE_W-1:0] cause_q;
	logic [`CAUSE_W-1:0] cause_d;
	logic [`CAUSE_W-1:0] causeSet;
	logic [`CAUSE_W-1:0] causeClr;
	apb_rsp_t    rsp_q;
	apb_rsp_t    rsp_d;
	logic        setup;
	logic        access;
	logic        hitCtrl;
	logic        hitStatus;
	logic [31:0] statusWord;

	// pull-up default: an open manual pin starts and stays high
	sync_filter
	#(
		.Width    (1),
		.Stable   (GlitchCycles),
		.ResetVal (1'b1)
	)
	u_mr_filter
	(
		.clk     (clk),
		.rst_b   (rst_b),
		.rawIn   (manual_reset_n_in),
		.filtOut (mrS)
	);

	// supply flag and kick pins only need synchronising
	sync_filter
	#(
		.Width    (3),
		.Stable   (KickCycles),
		.ResetVal (3'b000)
	)
	u_pin_sync
	(
		.clk     (clk),
		.rst_b   (rst_b),
		.rawIn   ({supplyOkIn, watchdog_kick_in, kickDrivenIn}),
		.filtOut ({supplyS, kickS, drivenS})
	);

	// recovery timer runs only in the recover state; any other state clears it
	period_timer
	#(
		.Limit (RecCycles)
	)
	u_rec_timer
	(
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (state_q != ST_RECOVER),
		.run   (1'b1),
		.count (),
		.done  (recDone)
	);

	// watchdog: cleared by reset, by kick edges, and when software or build disables it
	assign wdClr = !HasWatchdog || !wdEn_q || (state_q != ST_RUN) || kickEdge;

	period_timer
	#(
		.Limit (WdCycles),
		.W     (WdW)
	)
	u_wd_timer
	(
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (wdClr),
		.run   (1'b1),
		.count (wdCount),
		.done  (wdExpire)
	);

	// internal counter chain that services an undriven kick pin twice per timeout
	period_timer
	#(
		.Limit (SvcCycles)
	)
	u_svc_timer
	(
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (drivenS),
		.run   (1'b1),
		.count (),
		.done  (svcDone)
	);

	// a floating pin is replaced by the service pulse, so the watchdog never fires
	assign kickLevel = drivenS ? kickS : svcPulse_q;
	assign kickEdge  = kickLevel != kickPrev_q;

	always_comb
	begin
		kickPrev_d = kickLevel;
		svcPulse_d = svcDone;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			kickPrev_q <= 1'b0;
			svcPulse_q <= 1'b0;
		end
		else
		begin
			kickPrev_q <= kickPrev_d;
			svcPulse_q <= svcPulse_d;
		end
	end

	// reset sequencing; outputs are registered from the next state
	assign mrLow      = HasManual && !mrS;
	assign levelCause = !supplyS || mrLow;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				if (levelCause || wdExpire || swRst_q)
					state_d = ST_HOLD;
			end
			ST_RECOVER:
			begin
				// a bounce or a dip restarts the whole period
				if (levelCause || swRst_q)
					state_d = ST_HOLD;
				else if (recDone)
					state_d = ST_RUN;
			end
			ST_HOLD:
			begin
				if (!levelCause)
					state_d = ST_RECOVER;
			end
			default:
			begin
				state_d = ST_HOLD;
			end
		endcase
		rstHigh_d = state_d != ST_RUN;
		rstLow_d  = !rstHigh_d;
		odOe_d    = rstHigh_d;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q   <= ST_HOLD;
			rstHigh_q <= 1'b1;
			rstLow_q  <= 1'b0;
			odOe_q    <= 1'b1;
		end
		else
		begin
			state_q   <= state_d;
			rstHigh_q <= rstHigh_d;
			rstLow_q  <= rstLow_d;
			odOe_q    <= odOe_d;
		end
	end

	// absent outputs rest at their inactive level
	assign rstLowOut  = (LowOutMode == `LOW_OUT_PUSH_PULL) ? rstLow_q : 1'b1;
	assign rstHighOut = HasHighOut ? rstHigh_q : 1'b0;
	assign rstOdOut   = 1'b0;
	assign rstOdOe    = (LowOutMode == `LOW_OUT_OPEN_DRN) ? odOe_q : 1'b0;

	// APB slave: zero wait states, answer prepared in the setup cycle
	assign setup     = apbReq.psel && !apbReq.penable;
	assign access    = apbReq.psel && apbReq.penable && rsp_q.pready;
	assign hitCtrl   = apbReq.paddr == `OFF_CTRL;
	assign hitStatus = apbReq.paddr == `OFF_STATUS;

	assign causeSet = {swRst_q, wdExpire && state_q == ST_RUN, mrLow, !supplyS};
	assign causeClr = (access && apbReq.pwrite && hitStatus) ?
		apbReq.pwdata[`STAT_CAUSE_LSB +: `CAUSE_W] : '0;

	always_comb
	begin
		statusWord                                  = '0;
		statusWord[`STAT_RST_BIT]                   = rstHigh_q;
		statusWord[`STAT_SUPPLY_BIT]                = supplyS;
		statusWord[`STAT_MANUAL_BIT]                = mrLow;
		statusWord[`STAT_DRIVEN_BIT]                = drivenS;
		statusWord[`STAT_CAUSE_LSB +: `CAUSE_W]     = cause_q;
	end

	always_comb
	begin
		wdEn_d  = wdEn_q;
		swRst_d = 1'b0;
		// a cause arriving with its clear is kept
		cause_d = (cause_q & ~causeClr) | causeSet;
		if (access && apbReq.pwrite && hitCtrl)
		begin
			wdEn_d  = apbReq.pwdata[`CTRL_WDEN_BIT];
			swRst_d = apbReq.pwdata[`CTRL_SWRST_BIT];
		end
		rsp_d         = '0;
		rsp_d.pready  = setup;
		rsp_d.pslverr = setup && !(hitCtrl || hitStatus);
		if (setup && !apbReq.pwrite)
		begin
			if (hitCtrl)
				rsp_d.prdata[`CTRL_WDEN_BIT] = wdEn_q;
			else if (hitStatus)
				rsp_d.prdata = statusWord;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wdEn_q  <= `CTRL_WDEN_RESET;
			swRst_q <= 1'b0;
			cause_q <= '0;
			rsp_q   <= '0;
		end
		else
		begin
			wdEn_q  <= wdEn_d;
			swRst_q <= swRst_d;
			cause_q <= cause_d;
			rsp_q   <= rsp_d;
		end
	end

	assign apbRsp = rsp_q;

	// checking helpers: length of the current reset assertion
	logic [31:0] hiLen_q;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hiLen_q <= '0;
		else if (!rstHigh_q)
			hiLen_q <= '0;
		else if (hiLen_q != 32'hffff_ffff)
			hiLen_q <= hiLen_q + 32'h0000_0001;
	end

	a_cause_asserts: assert property (@(posedge clk) disable iff (!rst_b)
		levelCause |=> rstHigh_q && state_q == ST_HOLD)
		else $error("level cause did not assert reset");

	a_release_after: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_RECOVER && recDone && !levelCause && !swRst_q) |=> !rstHigh_q)
		else $error("reset not released after recovery period");

	a_min_length: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(rstHigh_q) |-> hiLen_q > RecCycles)
		else $error("reset shorter than recovery period");

	a_supply_restart: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_RECOVER && !supplyS) |=> state_q == ST_HOLD ##1 rstHigh_q)
		else $error("supply dip did not restart recovery");

	a_manual_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(mrLow && supplyS) [*2] |-> state_q == ST_HOLD && rstHigh_q)
		else $error("manual input low without held reset");

	a_wd_cleared: assert property (@(posedge clk) disable iff (!rst_b)
		rstHigh_q |=> wdCount == '0)
		else $error("watchdog counted during reset");

	a_kick_clears: assert property (@(posedge clk) disable iff (!rst_b)
		kickEdge |=> wdCount == '0)
		else $error("kick edge did not clear watchdog");

	a_wd_expire: assert property (@(posedge clk) disable iff (!rst_b)
		(wdExpire && state_q == ST_RUN) |=> state_q == ST_HOLD ##1 rstHigh_q)
		else $error("watchdog expiry did not assert reset");

	a_service_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(svcPulse_q) |=> !svcPulse_q && !drivenS |-> wdCount == '0)
		else $error("service pulse did not clear watchdog");

	a_outputs_inverse: assert property (@(posedge clk) disable iff (!rst_b)
		rstLow_q == !rstHigh_q)
		else $error("reset outputs not inverse");

	a_od_sink: assert property (@(posedge clk) disable iff (!rst_b)
		rstOdOe == ((LowOutMode == `LOW_OUT_OPEN_DRN) && rstHigh_q))
		else $error("open-drain enable not tied to reset");
endmodule

/* File: verilog/sync_filter.sv */
// two-flop synchroniser followed by a stable-level filter, one per bit
`timescale 1ns/1ps
module sync_filter
#(
	parameter int unsigned Width                = 1,
	parameter int unsigned Stable               = 1,
	parameter logic [Width-1:0] ResetVal        = '0
)
(
	input  wire logic             clk,      // system clock
	input  wire logic             rst_b,    // async reset, active low
	input  wire logic [Width-1:0] rawIn,    // asynchronous pin levels
	output logic      [Width-1:0] filtOut   // filtered, synchronous levels
);
	localparam int unsigned CW = $clog2(Stable + 1);

	if (Stable < 1)
	begin : g_bad_stable
		$error("sync_filter: Stable must be at least 1");
	end

	for (genvar i = 0; i < Width; i++)
	begin : g_bit
		logic          s1_q;
		logic          s2_q;
		logic          out_q;
		logic          out_d;
		logic [CW-1:0] cnt_q;
		logic [CW-1:0] cnt_d;

		// a level must differ for Stable samples before it is passed on
		always_comb
		begin
			out_d = out_q;
			cnt_d = '0;
			if (s2_q != out_q)
			begin
				if (cnt_q == CW'(Stable - 1))
					out_d = s2_q;
				else
					cnt_d = cnt_q + CW'(1);
			end
		end

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				s1_q  <= ResetVal[i];
				s2_q  <= ResetVal[i];
				out_q <= ResetVal[i];
				cnt_q <= '0;
			end
			else
			begin
				s1_q  <= rawIn[i];
				s2_q  <= s1_q;
				out_q <= out_d;
				cnt_q <= cnt_d;
			end
		end

		assign filtOut[i] = out_q;
	end
endmodule
